// ===== include/vdwmc_pkg.sv
// constants, register map and types for the video dram host controller
package vdwmc_pkg;

  // clock and timing
  localparam int CLK_MHZ         = 250;
  localparam int T_INIT_PAUSE_US = 200;
  localparam int INIT_PAUSE_CYC  = T_INIT_PAUSE_US * CLK_MHZ;
  localparam int T_PHASE_NS      = 60;
  localparam int PHASE_CYC       = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CYCLES     = 8;
  localparam int CNT_W           = 17;
  localparam int REP_W           = 4;

  // pin widths and address split
  localparam int MA_W   = 9;
  localparam int ADDR_W = 18;
  localparam int DQ_W   = 8;

  // register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;

  // field positions
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_OP_LSB   = 1;
  localparam int CTRL_CBR_BIT  = 4;
  localparam int DATA_MASK_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_INIT_BIT = 1;
  localparam int STAT_HALF_BIT = 2;
  localparam int STAT_RD_LSB   = 8;

  typedef enum logic [2:0] {
    OP_WRITE   = 3'h0,
    OP_MWRITE  = 3'h1,
    OP_READ    = 3'h2,
    OP_BLOCK   = 3'h3,
    OP_MBLOCK  = 3'h4,
    OP_FLASH   = 3'h5,
    OP_LCR     = 3'h6,
    OP_REFRESH = 3'h7
  } vdwmc_op_type;

  typedef enum logic [11:0] {
    S_PAUSE  = 12'h001,
    S_I_CAS  = 12'h002,
    S_I_RAS  = 12'h004,
    S_I_REST = 12'h008,
    S_SC_HI  = 12'h010,
    S_SC_LO  = 12'h020,
    S_IDLE   = 12'h040,
    S_ROW    = 12'h080,
    S_RAS    = 12'h100,
    S_COL    = 12'h200,
    S_CAS    = 12'h400,
    S_PRE    = 12'h800
  } vdwmc_state_type;

  typedef struct packed {
    vdwmc_state_type   state;
    vdwmc_op_type      op;
    logic              cbr;
    logic              cfg_cbr;
    logic              busy;
    logic              init_done;
    logic              go;
    logic              ack;
    logic [CNT_W-1:0]  cnt;
    logic [REP_W-1:0]  reps;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   wdata;
    logic [DQ_W-1:0]   mask;
    logic [DQ_W-1:0]   rdata;
    logic [31:0]       dat_o;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              xoe_n;
    logic              sfs;
    logic [MA_W-1:0]   ma;
    logic [DQ_W-1:0]   dq_o;
    logic              dq_oe_n;
    logic              sclk;
  } vdwmc_regs_type;

endpackage

// ===== rtl/vdwmc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module vdwmc_pin_sync
  import vdwmc_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // pins in, filtered level out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } vdwmc_sync_type;

  vdwmc_sync_type st_q;
  vdwmc_sync_type st_d;
  logic [W-1:0]   agree;

  ////////////////////////////////////////////////////////////////////////////
  // s1 feeds s2 only; a bit moves once s2 and s3 agree
  always_comb
  begin
    st_d    = st_q;
    agree   = ~(st_q.s2 ^ st_q.s3);
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.q  = (st_q.q & ~agree) | (st_q.s3 & agree);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level = st_q.q;

endmodule

// ===== rtl/vdwmc_host.sv
// host controller driving the random port of a dual-port video dram
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module vdwmc_host
  import vdwmc_pkg::*;
#(
  parameter int PAUSE_CYC = INIT_PAUSE_CYC
)(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // wishbone slave
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [3:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // dram strobes and controls
  output logic                 ras_n,
  output logic                 cas_n,
  output logic                 we_n,
  output logic                 transfer_output_enable_n,
  output logic                 special_function_select,
  output logic      [MA_W-1:0] multiplexed_address_pins,
  output logic                 serial_clock,
  output logic                 shift_port_gate_n,
  // dram data pins, three-signal form
  input  wire logic [DQ_W-1:0] ram_data_pins_i,
  output logic      [DQ_W-1:0] ram_data_pins_o,
  output logic                 ram_data_pins_oe_n,
  // serial half indicator from the device
  input  wire logic            split_half_indicator
);

  localparam logic [CNT_W-1:0] PH     = CNT_W'(PHASE_CYC - 1);
  localparam logic [CNT_W-1:0] PAUSE  = CNT_W'(PAUSE_CYC - 1);
  localparam logic [REP_W-1:0] NREP   = REP_W'(INIT_CYCLES);
  localparam vdwmc_regs_type   ST_RST = '{
    state: S_PAUSE, op: OP_WRITE, cbr: 1'b0, cfg_cbr: 1'b0, busy: 1'b1,
    init_done: 1'b0, go: 1'b0, ack: 1'b0, cnt: PAUSE, reps: '0,
    addr: '0, wdata: '0, mask: '0, rdata: '0, dat_o: '0,
    ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, xoe_n: 1'b1, sfs: 1'b0,
    ma: '0, dq_o: '0, dq_oe_n: 1'b1, sclk: 1'b0};

  vdwmc_regs_type  st_q;
  vdwmc_regs_type  st_d;
  logic [DQ_W:0]   pins_sync;
  logic [DQ_W-1:0] dq_sync;
  logic            half_sync;
  logic            req;
  logic [31:0]     wimg;

  vdwmc_pin_sync #(.W(DQ_W + 1)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    ({split_half_indicator, ram_data_pins_i}),
    .level  (pins_sync)
  );
  assign dq_sync   = pins_sync[DQ_W-1:0];
  assign half_sync = pins_sync[DQ_W];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  function automatic logic is_masked(input vdwmc_op_type op);
    return op == OP_MWRITE || op == OP_MBLOCK || op == OP_FLASH;
  endfunction

  function automatic logic is_write(input vdwmc_op_type op);
    return op != OP_READ && op != OP_REFRESH;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d    = st_q;
    wimg    = '0;
    st_d.ack = 1'b0;
    st_d.go  = 1'b0;
    if (st_q.cnt != '0)
      st_d.cnt = st_q.cnt - CNT_W'(1);
    // register bus: one-cycle answer; writes refused while busy, except the CBR bit during the pause
    req = wb_cyc_i & wb_stb_i & ~st_q.ack;
    if (req)
    begin
      st_d.ack   = 1'b1;
      st_d.dat_o = '0;
      case (wb_adr_i)
        REG_CTRL:
        begin
          st_d.dat_o[CTRL_OP_LSB +: 3] = st_q.op;
          st_d.dat_o[CTRL_CBR_BIT]     = st_q.cfg_cbr;
          wimg = merge(st_d.dat_o, wb_dat_i, wb_sel_i);
          if (wb_we_i && !st_q.busy)
          begin
            st_d.op      = vdwmc_op_type'(wimg[CTRL_OP_LSB +: 3]);
            st_d.go      = wimg[CTRL_GO_BIT];
          end
          // start-up choice only matters before the pause runs out
          if (wb_we_i && (!st_q.busy || st_q.state == S_PAUSE))
            st_d.cfg_cbr = wimg[CTRL_CBR_BIT];
        end
        REG_ADDR:
        begin
          st_d.dat_o[ADDR_W-1:0] = st_q.addr;
          wimg = merge(st_d.dat_o, wb_dat_i, wb_sel_i);
          if (wb_we_i && !st_q.busy)
            st_d.addr = wimg[ADDR_W-1:0];
        end
        REG_DATA:
        begin
          st_d.dat_o[DQ_W-1:0]               = st_q.wdata;
          st_d.dat_o[DATA_MASK_LSB +: DQ_W]  = st_q.mask;
          wimg = merge(st_d.dat_o, wb_dat_i, wb_sel_i);
          if (wb_we_i && !st_q.busy)
          begin
            st_d.wdata = wimg[DQ_W-1:0];
            st_d.mask  = wimg[DATA_MASK_LSB +: DQ_W];
          end
        end
        REG_STAT:
        begin
          st_d.dat_o[STAT_BUSY_BIT]         = st_q.busy;
          st_d.dat_o[STAT_INIT_BIT]         = st_q.init_done;
          st_d.dat_o[STAT_HALF_BIT]         = half_sync;
          st_d.dat_o[STAT_RD_LSB +: DQ_W]   = st_q.rdata;
        end
        default:
          st_d.dat_o = '0;
      endcase
    end
    // pin sequencer; every phase after the initial pause except idle lasts PH+1 cycles; idle waits for go
    case (st_q.state)
      S_PAUSE:
        if (st_q.cnt == '0)
        begin
          st_d.cbr   = st_q.cfg_cbr;
          st_d.reps  = '0;
          st_d.cnt   = PH;
          st_d.cas_n = ~st_q.cfg_cbr;
          st_d.state = S_I_CAS;
        end
      S_I_CAS:
        if (st_q.cnt == '0)
        begin
          st_d.ras_n = 1'b0;
          st_d.cnt   = PH;
          st_d.state = S_I_RAS;
        end
      S_I_RAS:
        if (st_q.cnt == '0)
        begin
          st_d.ras_n = 1'b1;
          st_d.cas_n = 1'b1;
          st_d.reps  = st_q.reps + REP_W'(1);
          st_d.cnt   = PH;
          st_d.state = S_I_REST;
        end
      S_I_REST:
        if (st_q.cnt == '0)
        begin
          st_d.cnt = PH;
          if (st_q.reps == NREP)
          begin
            st_d.reps  = '0;
            st_d.sclk  = 1'b1;
            st_d.state = S_SC_HI;
          end
          else
          begin
            st_d.cas_n = ~st_q.cbr;
            st_d.state = S_I_CAS;
          end
        end
      S_SC_HI:
        if (st_q.cnt == '0)
        begin
          st_d.sclk  = 1'b0;
          st_d.reps  = st_q.reps + REP_W'(1);
          st_d.cnt   = PH;
          st_d.state = S_SC_LO;
        end
      S_SC_LO:
        if (st_q.cnt == '0)
        begin
          st_d.cnt = PH;
          if (st_q.reps == NREP)
          begin
            st_d.init_done = 1'b1;
            st_d.busy      = 1'b0;
            st_d.state     = S_IDLE;
          end
          else
          begin
            st_d.sclk  = 1'b1;
            st_d.state = S_SC_HI;
          end
        end
      S_IDLE:
        if (st_q.go)
        begin
          // row half and strobe-fall levels; transfer input held high
          st_d.busy    = 1'b1;
          st_d.cnt     = PH;
          st_d.ma      = st_q.addr[ADDR_W-1:MA_W];
          st_d.xoe_n   = 1'b1;
          st_d.sfs     = st_q.op == OP_FLASH || st_q.op == OP_LCR;
          st_d.we_n    = ~is_masked(st_q.op);
          st_d.dq_o    = st_q.mask;
          st_d.dq_oe_n = ~is_masked(st_q.op);
          st_d.cas_n   = st_q.op != OP_REFRESH;
          st_d.state   = S_ROW;
        end
      S_ROW:
        if (st_q.cnt == '0)
        begin
          st_d.ras_n = 1'b0;
          st_d.cnt   = PH;
          st_d.state = S_RAS;
        end
      S_RAS:
        if (st_q.cnt == '0)
        begin
          st_d.cnt = PH;
          if (st_q.op == OP_REFRESH)
            st_d.state = S_PRE;
          else
          begin
            // single address change while the column strobe is high
            st_d.ma      = st_q.addr[MA_W-1:0];
            st_d.sfs     = st_q.op == OP_BLOCK || st_q.op == OP_MBLOCK
                           || st_q.op == OP_LCR;
            // write enable low ahead of the column strobe: early write only,
            // so the device never drives while we do
            st_d.we_n    = ~is_write(st_q.op);
            // block ops: low four bits are the column mask
            st_d.dq_o    = st_q.wdata;
            st_d.dq_oe_n = ~is_write(st_q.op);
            st_d.state   = S_COL;
          end
        end
      S_COL:
        if (st_q.cnt == '0)
        begin
          st_d.cas_n = 1'b0;
          st_d.xoe_n = is_write(st_q.op);
          st_d.cnt   = PH;
          st_d.state = S_CAS;
        end
      S_CAS:
        if (st_q.cnt == '0)
        begin
          if (st_q.op == OP_READ)
            st_d.rdata = dq_sync;
          st_d.cnt   = PH;
          st_d.state = S_PRE;
        end
      S_PRE:
      begin
        // address kept until the row strobe is back high
        st_d.ras_n   = 1'b1;
        st_d.cas_n   = 1'b1;
        st_d.we_n    = 1'b1;
        st_d.xoe_n   = 1'b1;
        st_d.sfs     = 1'b0;
        st_d.dq_oe_n = 1'b1;
        if (st_q.cnt == '0)
        begin
          st_d.busy  = 1'b0;
          st_d.state = S_IDLE;
        end
      end
      default:
        st_d = ST_RST;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  assign wb_dat_o                 = st_q.dat_o;
  assign wb_ack_o                 = st_q.ack;
  assign ras_n                    = st_q.ras_n;
  assign cas_n                    = st_q.cas_n;
  assign we_n                     = st_q.we_n;
  assign transfer_output_enable_n = st_q.xoe_n;
  assign special_function_select  = st_q.sfs;
  assign multiplexed_address_pins = st_q.ma;
  assign serial_clock             = st_q.sclk;
  assign shift_port_gate_n        = 1'b1;
  assign ram_data_pins_o          = st_q.dq_o;
  assign ram_data_pins_oe_n       = st_q.dq_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers
  logic [CNT_W-1:0] age;
  logic [1:0]       chg_ras;
  logic [1:0]       chg_hi;
  logic [REP_W:0]   n_ras;
  logic [REP_W:0]   n_sclk;
  logic [MA_W-1:0]  ma_prev;
  logic             ras_prev;
  logic             sclk_prev;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      age      <= '0;
      chg_ras  <= '0;
      chg_hi   <= '0;
      n_ras    <= '0;
      n_sclk    <= '0;
      ma_prev   <= '0;
      ras_prev  <= 1'b1;
      sclk_prev <= 1'b0;
    end
    else
    begin
      ma_prev  <= st_q.ma;
      ras_prev <= st_q.ras_n;
      sclk_prev <= st_q.sclk;
      if (age != '1)
        age <= age + CNT_W'(1);
      if (st_q.ras_n)
        chg_ras <= '0;
      else if (st_q.ma != ma_prev && chg_ras != 2'h3)
        chg_ras <= chg_ras + 2'h1;
      if (st_q.ras_n || !st_q.cas_n)
        chg_hi <= '0;
      else if (st_q.ma != ma_prev && chg_hi != 2'h3)
        chg_hi <= chg_hi + 2'h1;
      if (!st_q.init_done && ras_prev && !st_q.ras_n)
        n_ras <= n_ras + (REP_W+1)'(1);
      if (!st_q.init_done && !sclk_prev && st_q.sclk)
        n_sclk <= n_sclk + (REP_W+1)'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence cas_fall;
    $fell(cas_n) && !ras_n;
  endsequence

  sequence write_set_up;
    !we_n && $past(!we_n);
  endsequence

  a_addr_two_changes: assert property (
    !ras_n |-> chg_ras <= 2'h2)
    else $error("address changed more than twice in one row cycle");
  a_addr_cas_high: assert property (
    (!ras_n && cas_n) |-> chg_hi <= 2'h1)
    else $error("address changed twice while column strobe high");
  a_pause_first: assert property (
    $fell(ras_n) |-> age >= CNT_W'(PAUSE_CYC))
    else $error("row strobe before initial pause ended");
  a_init_trg_high: assert property (
    ($fell(ras_n) && !st_q.init_done) |-> transfer_output_enable_n)
    else $error("transfer input low during start-up row cycle");
  a_init_eight: assert property (
    $rose(st_q.init_done) |-> n_ras == (REP_W+1)'(INIT_CYCLES)
                           && n_sclk == (REP_W+1)'(INIT_CYCLES))
    else $error("start-up did not give eight row and eight serial cycles");
  a_init_cbr: assert property (
    ($fell(ras_n) && !st_q.init_done && st_q.cbr) |-> !cas_n)
    else $error("start-up refresh cycle without column strobe first");
  a_early_write: assert property (
    (cas_fall ##0 is_write(st_q.op))
    |-> write_set_up ##1 ram_data_pins_oe_n == 1'b0)
    else $error("write enable not set up before column strobe");

endmodule

// ===== test/vdwmc_dram_model.sv
// behavioural model of the dram random port facing the host controller
`timescale 1ns/1ps
module vdwmc_dram_model
  import vdwmc_pkg::*;
#(
  parameter real PAUSE_NS = 160.0
)(
  // strobes, controls and address
  input  wire logic            ras_n,
  input  wire logic            cas_n,
  input  wire logic            we_n,
  input  wire logic            xoe_n,
  input  wire logic            sfs,
  input  wire logic [MA_W-1:0] ma,
  input  wire logic            sclk,
  // data pins: resolved level in, own drive out
  input  wire logic [DQ_W-1:0] dq,
  output logic      [DQ_W-1:0] q,
  output logic                 q_oe_n,
  // serial side
  input  wire logic [8:0]      sam_loc,
  output logic                 half,
  // start-up and address checks
  output logic                 init_ok,
  output int                   viol,
  output int                   cbr_n
);
  logic [DQ_W-1:0] mem [int];
  logic [DQ_W-1:0] colr = 8'h00, msk, rd;
  logic [MA_W-1:0] row;
  logic            fr, wm, rdc = 1'b0, pause_ok = 1'b0;
  int              ras_i = 0, sclk_i = 0, chg = 0, chh = 0, a;

  initial
  begin
    viol = 0;
    cbr_n = 0;
  end

  function automatic logic [DQ_W-1:0] get(int x);
    return mem.exists(x) ? mem[x] : 8'h00;
  endfunction

  function automatic void put(int x, logic [7:0] d, logic [7:0] m);
    mem[x] = (get(x) & ~m) | (d & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge ras_n)
  begin
    if (ras_i + cbr_n == 0) pause_ok = $realtime >= PAUSE_NS;
    chg = 0;
    chh = 0;
    row = ma;
    fr = sfs;
    wm = !we_n;
    msk = we_n ? 8'hff : dq;
    if (!cas_n) cbr_n++;
    else if (xoe_n) ras_i++;
    // flash fills the whole row at once: slow but exact
    if (cas_n && xoe_n && fr && wm)
      for (int c = 0; c < 512; c++) put({row, c[8:0]}, colr, msk);
  end

  always @(negedge cas_n)
    if (!ras_n)
    begin
      a = {row, ma};
      rdc = we_n;
      if (fr && sfs && !wm) colr = dq;
      else if (!fr && sfs && !we_n)
      begin
        // fenced so the plain write below is not taken as the mask's else
        for (int k = 0; k < 4; k++)
          if (dq[k]) put({row, ma[8:2], k[1:0]}, colr, msk);
      end
      else if (!fr && !we_n) put(a, dq, msk);
      rd = get(a);
    end

  // no timing figures here, so any late write outside flash, block and colour-register cycles is a read-modify-write
  always @(negedge we_n)
    if (!ras_n && !cas_n && !fr && !sfs) put(a, dq, msk);

  assign q_oe_n = !(!ras_n && !cas_n && !xoe_n && rdc && !fr);
  assign q = rd;
  assign half = sam_loc >= 9'h100;
  assign init_ok = pause_ok && sclk_i >= INIT_CYCLES
    && (ras_i >= INIT_CYCLES || cbr_n >= INIT_CYCLES);

  always @(posedge sclk) sclk_i++;

  // sampled just after the change so a closing row strobe is not counted
  always @(ma)
  begin
    #0.5;
    if (!ras_n) chg++;
    if (!ras_n && cas_n) chh++;
    if (chg > 2 || chh > 1) viol++;
  end
endmodule

// ===== test/vdwmc_host_bench.sv
// self-checking bench for the video dram host controller
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module vdwmc_host_bench
  import vdwmc_pkg::*;
;
  localparam int PAUSE = 40;
  logic            clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0;
  logic            wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]      wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0]     wb_dat_i = 32'h0, wb_dat_o, seed = 32'h3e, x, y, r;
  logic            wb_ack_o, ras_n, cas_n, we_n, transfer_output_enable_n;
  logic            special_function_select, serial_clock, shift_port_gate_n;
  logic            ram_data_pins_oe_n, split_half_indicator, q_oe_n, init_ok;
  logic [MA_W-1:0] multiplexed_address_pins;
  logic [DQ_W-1:0] ram_data_pins_i, ram_data_pins_o, q, rcol = 8'h00;
  logic [DQ_W-1:0] rm [int];
  logic [8:0]      sam_loc = 9'h0;
  logic [8:0]      sv [4] = '{9'h0, 9'hff, 9'h100, 9'h1ff};
  int              bad_count = 0, total_checks = 0, viol, cbr_n, cb0;

  vdwmc_host #(.PAUSE_CYC(PAUSE)) u_dut (.clk, .resetn, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .ras_n, .cas_n, .we_n, .transfer_output_enable_n,
    .special_function_select, .multiplexed_address_pins, .serial_clock,
    .shift_port_gate_n, .ram_data_pins_i, .ram_data_pins_o,
    .ram_data_pins_oe_n, .split_half_indicator);

  vdwmc_dram_model #(.PAUSE_NS(PAUSE * 4.0)) u_dev (.ras_n, .cas_n, .we_n,
    .xoe_n(transfer_output_enable_n), .sfs(special_function_select),
    .ma(multiplexed_address_pins), .sclk(serial_clock),
    .dq(ram_data_pins_i), .q, .q_oe_n, .sam_loc,
    .half(split_half_indicator), .init_ok, .viol,
    .cbr_n);

  // released pins show a pattern that flips on every clock edge, never a stale value
  assign ram_data_pins_i = !ram_data_pins_oe_n ? ram_data_pins_o
    : !q_oe_n ? q : 8'h5a ^ {8{clk}};

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] rget(int a);
    return rm.exists(a) ? rm[a] : 8'h00;
  endfunction

  function automatic void rput(int a, logic [7:0] d, logic [7:0] m);
    rm[a] = (rget(a) & ~m) | (d & m);
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (n >= 20) bad_count++;
    if (n >= 20) conclude();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wait_idle(output logic [31:0] s);
    int n;
    n = 0;
    do wb(1'b0, REG_STAT, 32'h0, s);
    while (s[STAT_BUSY_BIT] !== 1'b0 && ++n < 400);
    if (n >= 400) bad_count++;
    if (n >= 400) conclude();
  endtask

  task automatic op(input vdwmc_op_type o, input logic [17:0] a,
                    input logic [7:0] d, input logic [7:0] m);
    logic [31:0] s;
    int          c0;
    c0 = cbr_n;
    wb(1'b1, REG_ADDR, {14'h0, a}, s);
    wb(1'b1, REG_DATA, {16'h0, m, d}, s);
    wb(1'b1, REG_CTRL, {28'h0, o, 1'b1}, s);
    wait_idle(s);
    case (o)
      OP_WRITE: rput(a, d, 8'hff);
      OP_MWRITE: rput(a, d, m);
      OP_BLOCK, OP_MBLOCK:
        for (int k = 0; k < 4; k++)
          if (d[k]) rput({a[17:2], k[1:0]}, rcol, o == OP_BLOCK ? 8'hff : m);
      OP_FLASH: for (int k = 0; k < 512; k++) rput({a[17:9], k[8:0]}, rcol, m);
      OP_LCR: rcol = d;
      OP_READ: `CHK(s[15:8], rget(a))
      default: `CHK(cbr_n, c0 + 1)
    endcase
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    `CHK({ras_n, cas_n, we_n, ram_data_pins_oe_n, shift_port_gate_n}, 5'h1f)
    wb(1'b0, REG_STAT, 32'h0, r);
    `CHK(r[STAT_BUSY_BIT], 1'b1)
    wait_idle(r);
    `CHK(r[STAT_INIT_BIT], 1'b1)
    `CHK(init_ok, 1'b1)
    wb(1'b0, 4'h2, 32'h0, r);
    `CHK(r, 32'h0)
    for (int i = 0; i < 24; i++)
    begin
      x = rnd();
      y = rnd();
      op(vdwmc_op_type'(i[2:0]), x[17:0], y[7:0], y[15:8]);
      for (int k = 0; k < 4; k++)
        op(OP_READ, {x[17:2], k[1:0]}, 8'h0, 8'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      sam_loc <= sv[i];
      repeat (8) @(posedge clk);
      wb(1'b0, REG_STAT, 32'h0, r);
      `CHK(r[STAT_HALF_BIT], sv[i] >= 9'h100)
    end
    `CHK(viol, 0)
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    // second start-up runs on column-before-row cycles
    cb0 = cbr_n;
    wb(1'b1, REG_CTRL, 32'h1 << CTRL_CBR_BIT, r);
    wait_idle(r);
    `CHK(cbr_n - cb0, INIT_CYCLES)
    op(OP_READ, x[17:0], 8'h0, 8'h0);
    conclude();
  end

  initial
  begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule
